//--- rtl/wwd_pkg.sv
// Constants, field layouts and types shared by the windowed watchdog
package wwd_pkg;

  // Register byte offsets on the APB bus
  localparam int unsigned    ADDR_W          = 8;
  localparam logic [7:0]     OFS_CTRL_0      = 8'h00;
  localparam logic [7:0]     OFS_CTRL_1      = 8'h04;
  localparam logic [7:0]     OFS_TIMER       = 8'h08;
  localparam logic [7:0]     OFS_PSC_LOW     = 8'h0C;
  localparam logic [7:0]     OFS_PSC_HIGH    = 8'h10;
  localparam logic [7:0]     OFS_PWR_CTRL_0  = 8'h14;

  // Field positions
  localparam int unsigned    CTRL0_SEN_BIT   = 0;
  localparam int unsigned    CTRL0_PER_LSB   = 1;
  localparam int unsigned    CTRL1_CS_LSB    = 0;
  localparam int unsigned    CTRL1_WIN_LSB   = 4;
  localparam int unsigned    TIMER_PSC_LSB   = 0;
  localparam int unsigned    TIMER_TMR_LSB   = 3;
  localparam int unsigned    PWR_WV_BIT      = 0;
  localparam int unsigned    PWR_TO_BIT      = 1;

  // Widths
  localparam int unsigned    PER_W           = 5;
  localparam int unsigned    CS_W            = 3;
  localparam int unsigned    WIN_W           = 3;
  localparam int unsigned    PSC_W           = 18;
  localparam int unsigned    TMR_W           = 5;

  // Reset values; period code 11 is 2^11 ms, the nominal two seconds
  localparam logic           SEN_RST         = 1'b0;
  localparam logic [4:0]     PER_RST         = 5'h0B;
  localparam logic [2:0]     CS_RST          = 3'h0;
  localparam logic [2:0]     WIN_RST         = 3'h7;
  localparam logic           WV_RST          = 1'b1;
  localparam logic           TO_RST          = 1'b0;

  // Enable configuration codes
  localparam logic [1:0]     EN_OFF          = 2'h0;
  localparam logic [1:0]     EN_SOFT         = 2'h1;
  localparam logic [1:0]     EN_OFF_SLEEP    = 2'h2;
  localparam logic [1:0]     EN_ALWAYS       = 2'h3;

  // Selector codes
  localparam logic [4:0]     PER_FROM_REG    = 5'h1F;
  localparam logic [4:0]     PER_MAX         = 5'h12;
  localparam logic [2:0]     WIN_FROM_REG    = 3'h7;
  localparam logic [2:0]     CS_LOW_OSC      = 3'h0;
  localparam logic [2:0]     CS_MID_OSC      = 3'h1;

  // Window open threshold: open once timer >= WIN_BASE - WIN_STEP * window
  localparam logic [5:0]     WIN_BASE        = 6'h1C;
  localparam logic [5:0]     WIN_STEP_SHIFT  = 6'h02;

  // Time base: nominal oscillator rates and the 1 ms minimum interval
  localparam int unsigned    LOW_OSC_HZ      = 31000;
  localparam int unsigned    MID_OSC_HZ      = 31250;
  localparam int unsigned    MIN_PERIOD_MS   = 1;

  // Configuration word straps
  typedef struct packed {
    logic [1:0] enable;
    logic [2:0] clk_select;
    logic [4:0] period_select;
    logic [2:0] window_select;
  } wwd_cfg_t;

  // APB response state
  typedef enum logic [1:0] {
    AP_IDLE = 2'b01,
    AP_RESP = 2'b10
  } wwd_apb_st_t;

endpackage

//--- rtl/wwd_top.sv
// Windowed watchdog timer with APB register slave
// What this block does
// - Count from a 31 kHz or 31.25 kHz oscillator tick, picked by configuration or control register 1.
// - Enable code 1x takes the clock source from the clock-select configuration.
// - Enable code 01 runs on the soft-enable bit, source from control register 1.
// - Enable code 11 keeps the watchdog active always, sleep included.
// - Enable code 10 is active awake and disabled while asleep.
// - Enable code 01 is active exactly while soft-enable is set; sleep irrelevant.
// - Enable code 00 disables the watchdog in every state.
// - Period select 11111 takes timeout from control 0 period field, else configuration.
// - With period select 11111 the timeout period defaults after reset to nominal two seconds.
// - In windowed mode a clear outside the window is a violation and resets.
// - Window comes from window-select configuration unless it is 111, then control 1.
// - Window open is decided from the five top bits of the timer register.
// - Violation resets and clears the violation flag; reset or firmware sets it.
// - Count clears on reset, clear, sleep, wake, disable, start-up timer, control write.
// - In windowed mode a read of control 0 arms; only armed clears in the open window restart the count without a reset.
// - Unarmed clear in windowed mode is a violation, window open or not.
// - An 18-bit read-only prescale count spans low, high and timer registers.
`timescale 1ns/100ps
`default_nettype none

module wwd_top (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [7:0]       paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output var  logic [31:0]      prdata,
  output var  logic             pready,
  output var  logic             pslverr,
  input  wire wwd_pkg::wwd_cfg_t cfg_word,
  input  wire logic             low_freq_internal_osc,
  input  wire logic             mid_freq_internal_osc,
  input  wire logic             sleep_mode,
  input  wire logic             wake_by_irq,
  input  wire logic             osc_startup_timer,
  input  wire logic             watchdog_clear_instr,
  output var  logic             wdog_reset
);

  // Pin-side synchronisers; the first stage feeds only the second
  logic [1:0]                   low_sync_r;
  logic [1:0]                   mid_sync_r;
  logic                         low_last_r;
  logic                         mid_last_r;
  wwd_pkg::wwd_cfg_t            cfg_meta_r;
  wwd_pkg::wwd_cfg_t            cfg_r;

  // Software-visible state
  logic                         soft_enable_bit_r;
  logic [wwd_pkg::PER_W-1:0]    period_field_r;
  logic [wwd_pkg::CS_W-1:0]     clk_sel_r;
  logic [wwd_pkg::WIN_W-1:0]    window_r;
  logic                         window_violation_flag_r;
  logic                         timeout_flag_r;

  // Counter state
  logic [wwd_pkg::PSC_W-1:0]    prescale_count_r;
  logic [wwd_pkg::TMR_W-1:0]    tmr_r;
  logic                         armed_r;
  logic                         sleep_last_r;

  // APB state
  wwd_pkg::wwd_apb_st_t         apb_st_r;

  // Derived terms
  logic                         low_rise;
  logic                         mid_rise;
  logic                         active;
  logic [wwd_pkg::CS_W-1:0]     clk_src;
  logic                         tick;
  logic [wwd_pkg::PER_W-1:0]    period_sel;
  logic [wwd_pkg::PER_W-1:0]    period_eff;
  logic [wwd_pkg::PSC_W-1:0]    prescale_term;
  logic [wwd_pkg::WIN_W-1:0]    window_sel;
  logic                         windowed;
  logic [5:0]                   window_limit;
  logic                         window_open;
  logic                         step;
  logic                         wrap;
  logic                         timeout;
  logic                         violation;
  logic                         valid_clear;
  logic                         count_clear;
  logic                         acc;
  logic                         wr_acc;
  logic                         rd_acc;
  logic                         ctrl_write;
  logic                         sleep_rise;
  logic                         mapped;
  logic [31:0]                  rd_mux;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Idle-high reset, so release never shows a false rising edge
      low_sync_r <= 2'h3;
      mid_sync_r <= 2'h3;
      low_last_r <= 1'b1;
      mid_last_r <= 1'b1;
      cfg_meta_r <= '0;
      cfg_r      <= '0;
    end else begin
      low_sync_r <= {low_sync_r[0], low_freq_internal_osc};
      mid_sync_r <= {mid_sync_r[0], mid_freq_internal_osc};
      low_last_r <= low_sync_r[1];
      mid_last_r <= mid_sync_r[1];
      cfg_meta_r <= cfg_word;
      cfg_r      <= cfg_meta_r;
    end
  end

  assign low_rise = low_sync_r[1] & ~low_last_r;
  assign mid_rise = mid_sync_r[1] & ~mid_last_r;

  // Operating mode
  always_comb begin
    unique case (cfg_r.enable)
      wwd_pkg::EN_ALWAYS:    active = 1'b1;
      wwd_pkg::EN_OFF_SLEEP: active = ~sleep_mode;
      wwd_pkg::EN_SOFT:      active = soft_enable_bit_r;
      default:               active = 1'b0;
    endcase
  end

  // Configuration picks the source in hardware modes, the register otherwise
  assign clk_src = cfg_r.enable[1] ? cfg_r.clk_select : clk_sel_r;
  assign tick    = (clk_src == wwd_pkg::CS_MID_OSC) ? mid_rise : low_rise;

  // Period codes past 18 saturate at the 256 s ceiling of the prescaler
  assign period_sel = (cfg_r.period_select == wwd_pkg::PER_FROM_REG) ?
                      period_field_r : cfg_r.period_select;
  assign period_eff = (period_sel > wwd_pkg::PER_MAX) ? wwd_pkg::PER_MAX : period_sel;
  assign prescale_term = wwd_pkg::PSC_W'((19'h0_0001 << period_eff) - 19'h0_0001);

  assign window_sel = (cfg_r.window_select == wwd_pkg::WIN_FROM_REG) ?
                      window_r : cfg_r.window_select;
  assign windowed     = (window_sel != wwd_pkg::WIN_FROM_REG);
  assign window_limit = wwd_pkg::WIN_BASE -
                        ({3'h0, window_sel} << wwd_pkg::WIN_STEP_SHIFT);
  assign window_open  = ({1'b0, tmr_r} >= window_limit);

  assign step    = active & tick;
  assign wrap    = step & (prescale_count_r == prescale_term);
  assign timeout = wrap & (tmr_r == {wwd_pkg::TMR_W{1'b1}});

  // A clear without arming, or before the window opens, is a violation
  assign violation   = watchdog_clear_instr & active & windowed &
                       (~armed_r | ~window_open);
  assign valid_clear = watchdog_clear_instr & ~violation;

  assign acc        = (apb_st_r == wwd_pkg::AP_RESP) & psel & penable;
  assign wr_acc     = acc & pwrite;
  assign rd_acc     = acc & ~pwrite;
  assign ctrl_write = wr_acc & ((paddr == wwd_pkg::OFS_CTRL_0) |
                                (paddr == wwd_pkg::OFS_CTRL_1));
  assign sleep_rise = sleep_mode & ~sleep_last_r;

  // Timeout and violation also restart the count for the reset that follows
  assign count_clear = valid_clear | sleep_rise | wake_by_irq | ~active |
                       osc_startup_timer | ctrl_write | timeout | violation;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_last_r <= 1'b0;
    end else begin
      sleep_last_r <= sleep_mode;
    end
  end

  // Prescaler and window timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_count_r <= '0;
      tmr_r            <= '0;
    end else if (count_clear) begin
      prescale_count_r <= '0;
      tmr_r            <= '0;
    end else if (wrap) begin
      prescale_count_r <= '0;
      tmr_r            <= tmr_r + 5'h01;
    end else if (step) begin
      prescale_count_r <= prescale_count_r + 18'h0_0001;
    end
  end

  // Arming; any clear or restart of the count drops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b0;
    end else if (count_clear | watchdog_clear_instr) begin
      armed_r <= 1'b0;
    end else if (rd_acc & (paddr == wwd_pkg::OFS_CTRL_0)) begin
      armed_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_reset <= 1'b0;
    end else begin
      wdog_reset <= timeout | violation;
    end
  end

  // Control registers; byte lane 0 carries every field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_enable_bit_r <= wwd_pkg::SEN_RST;
      period_field_r    <= wwd_pkg::PER_RST;
      clk_sel_r         <= wwd_pkg::CS_RST;
      window_r          <= wwd_pkg::WIN_RST;
    end else if (wr_acc & pstrb[0]) begin
      if (paddr == wwd_pkg::OFS_CTRL_0) begin
        soft_enable_bit_r <= pwdata[wwd_pkg::CTRL0_SEN_BIT];
        period_field_r    <= pwdata[wwd_pkg::CTRL0_PER_LSB +: wwd_pkg::PER_W];
      end
      if (paddr == wwd_pkg::OFS_CTRL_1) begin
        clk_sel_r <= pwdata[wwd_pkg::CTRL1_CS_LSB +: wwd_pkg::CS_W];
        window_r  <= pwdata[wwd_pkg::CTRL1_WIN_LSB +: wwd_pkg::WIN_W];
      end
    end
  end

  // Status flags; the hardware event wins over a same-cycle software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      window_violation_flag_r <= wwd_pkg::WV_RST;
      timeout_flag_r          <= wwd_pkg::TO_RST;
    end else begin
      if (violation) begin
        window_violation_flag_r <= 1'b0;
      end else if (wr_acc & pstrb[0] & (paddr == wwd_pkg::OFS_PWR_CTRL_0)) begin
        window_violation_flag_r <= pwdata[wwd_pkg::PWR_WV_BIT];
      end
      if (timeout) begin
        timeout_flag_r <= 1'b1;
      end else if (wr_acc & pstrb[0] & (paddr == wwd_pkg::OFS_PWR_CTRL_0)) begin
        timeout_flag_r <= pwdata[wwd_pkg::PWR_TO_BIT];
      end
    end
  end

  // Read mux; prescale registers have no write path at all
  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr)
      wwd_pkg::OFS_CTRL_0: begin
        rd_mux[wwd_pkg::CTRL0_SEN_BIT] = soft_enable_bit_r;
        rd_mux[wwd_pkg::CTRL0_PER_LSB +: wwd_pkg::PER_W] = period_field_r;
      end
      wwd_pkg::OFS_CTRL_1: begin
        rd_mux[wwd_pkg::CTRL1_CS_LSB +: wwd_pkg::CS_W]   = clk_sel_r;
        rd_mux[wwd_pkg::CTRL1_WIN_LSB +: wwd_pkg::WIN_W] = window_r;
      end
      wwd_pkg::OFS_TIMER: begin
        rd_mux[wwd_pkg::TIMER_PSC_LSB +: 2] = prescale_count_r[17:16];
        rd_mux[wwd_pkg::TIMER_TMR_LSB +: wwd_pkg::TMR_W] = tmr_r;
      end
      wwd_pkg::OFS_PSC_LOW: begin
        rd_mux[7:0] = prescale_count_r[7:0];
      end
      wwd_pkg::OFS_PSC_HIGH: begin
        rd_mux[7:0] = prescale_count_r[15:8];
      end
      wwd_pkg::OFS_PWR_CTRL_0: begin
        rd_mux[wwd_pkg::PWR_WV_BIT] = window_violation_flag_r;
        rd_mux[wwd_pkg::PWR_TO_BIT] = timeout_flag_r;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // APB slave: one wait-free access cycle, answer prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_st_r <= wwd_pkg::AP_IDLE;
      pready   <= 1'b0;
      prdata   <= 32'h0000_0000;
      pslverr  <= 1'b0;
    end else begin
      unique case (apb_st_r)
        wwd_pkg::AP_IDLE: begin
          if (psel & ~penable) begin
            apb_st_r <= wwd_pkg::AP_RESP;
            pready   <= 1'b1;
            prdata   <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr  <= ~mapped;
          end
        end
        wwd_pkg::AP_RESP: begin
          apb_st_r <= wwd_pkg::AP_IDLE;
          pready   <= 1'b0;
          pslverr  <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

//--- test/wwd_top_assertions.sv
// Concurrent checks on the windowed watchdog ports
`timescale 1ns/100ps
`default_nettype none
module wwd_top_chk (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [7:0]        paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire wwd_pkg::wwd_cfg_t cfg_word,
  input wire logic              low_freq_internal_osc,
  input wire logic              mid_freq_internal_osc,
  input wire logic              sleep_mode,
  input wire logic              wake_by_irq,
  input wire logic              osc_startup_timer,
  input wire logic              watchdog_clear_instr,
  input wire logic              wdog_reset
);
  logic [2:0] age_r;
  logic       armed_r;
  logic       mapped;
  assign mapped = paddr inside {wwd_pkg::OFS_CTRL_0, wwd_pkg::OFS_CTRL_1, wwd_pkg::OFS_TIMER,
                  wwd_pkg::OFS_PSC_LOW, wwd_pkg::OFS_PSC_HIGH, wwd_pkg::OFS_PWR_CTRL_0};
  // Straps cross a synchroniser, so trust them only once settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_r <= 3'h0;
    end else if (!$stable(cfg_word)) begin
      age_r <= 3'h0;
    end else if (age_r != 3'h7) begin
      age_r <= age_r + 3'h1;
    end
  end
  // Arming read seen since the last clear pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b0;
    end else if (watchdog_clear_instr) begin
      armed_r <= 1'b0;
    end else if (psel && penable && pready && !pwrite && paddr == wwd_pkg::OFS_CTRL_0) begin
      armed_r <= 1'b1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_rst_one_cycle: assert property (wdog_reset |=> !wdog_reset)
    else $error("watchdog reset wider than one cycle");
  chk_off_quiet: assert property (age_r == 3'h7 && cfg_word.enable == wwd_pkg::EN_OFF |-> !wdog_reset)
    else $error("reset while disabled");
  chk_sleep_quiet: assert property ((age_r == 3'h7 && cfg_word.enable == wwd_pkg::EN_OFF_SLEEP && sleep_mode) [*3] |-> !wdog_reset)
    else $error("reset while asleep in mode off-in-sleep");
  chk_unarmed_viol: assert property (age_r == 3'h7 && cfg_word.enable == wwd_pkg::EN_ALWAYS && cfg_word.window_select != wwd_pkg::WIN_FROM_REG && watchdog_clear_instr && !armed_r |-> ##[1:2] wdog_reset)
    else $error("unarmed clear gave no reset");
  chk_ready_answer: assert property (psel && !penable |=> pready)
    else $error("no answer in first access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready wider than one cycle");
  chk_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("error flag does not follow address map");
  chk_err_zero: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused access returned data");
  cov_reset: cover property (wdog_reset);
  cov_err: cover property (pready && pslverr);
  cov_armed: cover property (watchdog_clear_instr && armed_r);
endmodule
bind wwd_top wwd_top_chk u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cfg_word(cfg_word),
  .low_freq_internal_osc(low_freq_internal_osc), .mid_freq_internal_osc(mid_freq_internal_osc),
  .sleep_mode(sleep_mode), .wake_by_irq(wake_by_irq), .osc_startup_timer(osc_startup_timer),
  .watchdog_clear_instr(watchdog_clear_instr), .wdog_reset(wdog_reset));
`default_nettype wire

//--- test/windowed_watchdog_timer_bench.sv
// Self-checking bench for the windowed watchdog
`timescale 1ns/100ps
`default_nettype none
module windowed_watchdog_timer_bench;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic [3:0]        pstrb = 4'hF;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  wwd_pkg::wwd_cfg_t cfg_word = '0;
  logic              low_osc = 1'b0;
  logic              mid_osc = 1'b0;
  logic              sleep_mode = 1'b0;
  logic              clr_pulse = 1'b0;
  logic              wake_irq = 1'b0;
  logic              ost_run = 1'b0;
  logic              wdog_reset;
  logic [31:0]       q;
  logic              e;
  int                bad_count = 0;
  int                checks = 0;
  int                pulses = 0;
  int                cyc = 0;
  wwd_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg_word(cfg_word), .low_freq_internal_osc(low_osc),
    .mid_freq_internal_osc(mid_osc), .sleep_mode(sleep_mode), .wake_by_irq(wake_irq),
    .osc_startup_timer(ost_run), .watchdog_clear_instr(clr_pulse), .wdog_reset(wdog_reset));
  always #4 pclk = ~pclk;
  // Low oscillator tick every 8 cycles keeps a code-0 timeout near 256 cycles; mid ticks every 16
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    low_osc <= cyc[2];
    mid_osc <= cyc[3];
    if (wdog_reset === 1'b1) pulses <= pulses + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("Counts: checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cmp({31'h0, e}, {31'h0, !(a inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14})}, "error");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0000_0000);
    cmp(q, exp, "read");
  endtask
  task automatic restart(input logic [1:0] en, input logic [4:0] ps, input logic [2:0] ws);
    @(posedge pclk);
    presetn <= 1'b0;
    cfg_word <= '{enable: en, clk_select: 3'h0, period_select: ps, window_select: ws};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  task automatic clr();
    @(posedge pclk);
    clr_pulse <= 1'b1;
    @(posedge pclk);
    clr_pulse <= 1'b0;
  endtask
  task automatic expect_pulses(input int n, input int exp);
    int p0;
    p0 = pulses;
    repeat (n) @(posedge pclk);
    cmp(32'(pulses - p0), 32'(exp), "reset pulses");
  endtask
  task automatic t_regs();
    restart(wwd_pkg::EN_OFF, 5'h00, 3'h7);
    rd(wwd_pkg::OFS_CTRL_0, 32'h0000_0016);
    rd(wwd_pkg::OFS_CTRL_1, 32'h0000_0070);
    rd(wwd_pkg::OFS_PWR_CTRL_0, 32'h0000_0001);
    apb(wwd_pkg::OFS_PSC_LOW, 1'b1, 32'h0000_00FF);
    rd(wwd_pkg::OFS_PSC_LOW, 32'h0000_0000);
    rd(wwd_pkg::OFS_PSC_HIGH, 32'h0000_0000);
    rd(wwd_pkg::OFS_TIMER, 32'h0000_0000);
    pstrb <= 4'hE;
    apb(wwd_pkg::OFS_CTRL_1, 1'b1, 32'h0000_0000);
    pstrb <= 4'hF;
    rd(wwd_pkg::OFS_CTRL_1, 32'h0000_0070);
    rd(8'h20, 32'h0000_0000);
    clr();
    expect_pulses(600, 0);
  endtask
  task automatic t_modes();
    restart(wwd_pkg::EN_ALWAYS, 5'h00, 3'h7);
    sleep_mode <= 1'b1;
    expect_pulses(400, 1);
    rd(wwd_pkg::OFS_PWR_CTRL_0, 32'h0000_0003);
    restart(wwd_pkg::EN_OFF_SLEEP, 5'h00, 3'h7);
    expect_pulses(600, 0);
    sleep_mode <= 1'b0;
    expect_pulses(400, 1);
    restart(wwd_pkg::EN_SOFT, 5'h1F, 3'h7);
    expect_pulses(400, 0);
    sleep_mode <= 1'b1;
    apb(wwd_pkg::OFS_CTRL_0, 1'b1, 32'h0000_0001);
    repeat (200) @(posedge pclk);
    apb(wwd_pkg::OFS_CTRL_1, 1'b1, 32'h0000_0070);
    expect_pulses(200, 0);
    expect_pulses(200, 1);
    sleep_mode <= 1'b0;
  endtask
  task automatic t_window();
    restart(wwd_pkg::EN_ALWAYS, 5'h00, 3'h3);
    rd(wwd_pkg::OFS_CTRL_0, 32'h0000_0016);
    clr();
    expect_pulses(4, 1);
    rd(wwd_pkg::OFS_PWR_CTRL_0, 32'h0000_0000);
    restart(wwd_pkg::EN_ALWAYS, 5'h00, 3'h3);
    repeat (180) @(posedge pclk);
    rd(wwd_pkg::OFS_CTRL_0, 32'h0000_0016);
    clr();
    expect_pulses(150, 0);
    clr();
    expect_pulses(4, 1);
    restart(wwd_pkg::EN_ALWAYS, 5'h00, 3'h7);
    apb(wwd_pkg::OFS_CTRL_1, 1'b1, 32'h0000_0030);
    rd(wwd_pkg::OFS_CTRL_0, 32'h0000_0016);
    clr();
    expect_pulses(4, 1);
    apb(wwd_pkg::OFS_PWR_CTRL_0, 1'b1, 32'h0000_0001);
    rd(wwd_pkg::OFS_PWR_CTRL_0, 32'h0000_0001);
  endtask
  // Wake and start-up timer restarts, then the mid oscillator picked by register
  task automatic t_events();
    restart(wwd_pkg::EN_ALWAYS, 5'h00, 3'h7);
    repeat (200) @(posedge pclk);
    wake_irq <= 1'b1;
    @(posedge pclk);
    wake_irq <= 1'b0;
    expect_pulses(200, 0);
    expect_pulses(200, 1);
    ost_run <= 1'b1;
    expect_pulses(300, 0);
    ost_run <= 1'b0;
    expect_pulses(300, 1);
    restart(wwd_pkg::EN_SOFT, 5'h1F, 3'h7);
    apb(wwd_pkg::OFS_CTRL_1, 1'b1, 32'h0000_0071);
    apb(wwd_pkg::OFS_CTRL_0, 1'b1, 32'h0000_0001);
    expect_pulses(400, 0);
    expect_pulses(200, 1);
  endtask
  initial begin
    t_regs();
    t_modes();
    t_window();
    t_events();
    end_sim();
  end
endmodule
`default_nettype wire
